// ### design/srsel_top.sv
/*
 * srsel_top: on-line stream selection, latching coil pulses, switch supervision,
 * indicators and remote monitor outputs of a one-for-one redundancy controller.
 * Assumes synchronous inputs, a non-volatile store outside that presents the last
 * choice at power-up, and tell-back contacts that read one-hot per switch.
 */
`timescale 1ns/1ps
module srsel_top
    import srsel_pkg::*;
#(
    parameter int unsigned SW_MAX = SW_MAX_CYC,   // longest switching time in cycles
    parameter int unsigned COIL   = SW_TYP_CYC,   // coil pulse length in cycles
    parameter int unsigned BLANK  = BLANK_CYC     // switch fault indicator dark time
) (
    input  wire logic         mclk_in,            // system clock
    input  wire logic         sys_rst_in,         // synchronous reset, active high
    input  srsel_alarm_t      alarm_in [2],       // transceiver alarm lines
    input  wire logic         ign_warm_in,        // config: ignore warm-up alarms
    input  wire logic         fan_en_in,          // config: recognise fan faults
    input  wire logic         auto_in,            // local mode switch, high = auto
    input  wire logic         rem_manual_in,      // remote forces manual mode
    input  wire logic         local_sel_in,       // local stream selector, high = stream 2
    input  wire logic         rem_sel_en_in,      // remote selection takes over
    input  wire logic         rem_sel_in,         // remote stream choice, high = stream 2
    input  srsel_amp_t        amp_ctl_in,         // amplifier control selector
    input  wire logic         rem_amp_act_in,     // remote activate request
    input  wire logic [1:0]   tx_tell_in,         // transmit switch tell-back, one bit per stream
    input  wire logic [1:0]   rx_tell_in,         // receive switch tell-back, one bit per stream
    input  wire logic         nv_stream_in,       // stored on-line stream
    output srsel_coil_t       coil_out,           // coil commands
    output logic              nv_write_out,       // store pulse for the stored stream
    output logic              nv_stream_out,      // value to store
    output srsel_status_t     status_out,         // local indicators
    output srsel_status_t     rem_status_out,     // remote monitor outputs
    output logic [1:0]        amp_en_out          // amplifier enable per stream
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [1:0]     rank [2];          // health rank per stream
    logic           amp_inh;           // inhibit position
    logic           manual;            // manual mode in force
    logic           man_choice;        // manual stream choice
    logic           want_swap;         // auto decision to swap
    logic           target;            // stream wanted on line
    logic           tell_ok;           // tell-back matches selection
    logic           any_fault;         // health of stream seen as fault

    srsel_state_t   state;             // sequencer state
    srsel_state_t   next_state;
    logic           sel;               // stream on line
    logic           next_sel;
    logic [31:0]    cnt;               // pulse and settle timer
    logic [31:0]    next_cnt;
    logic [31:0]    blank;             // indicator dark timer
    logic [31:0]    next_blank;
    logic [1:0]     coil;              // active coil, one-hot or idle
    logic [1:0]     next_coil;
    logic           sw_fault;          // supervised switch fault
    logic           next_sw_fault;
    logic           nv_wr;             // store pulse
    logic           next_nv_wr;

    srsel_status_t  stat;              // registered indicators
    srsel_status_t  next_stat;
    logic [1:0]     amp_en;            // registered amplifier enables
    logic [1:0]     next_amp_en;

    ////////////////////////////////////////////////////////////////////////////
    // alarm decode
    srsel_health u_health (
        .mclk_in     (mclk_in),
        .sys_rst_in  (sys_rst_in),
        .alarm_in    (alarm_in),
        .ign_warm_in (ign_warm_in),
        .fan_en_in   (fan_en_in),
        .amp_inh_in  (amp_inh),
        .rank_out    (rank)
    );

    ////////////////////////////////////////////////////////////////////////////
    // selection decision
    assign amp_inh    = (amp_ctl_in == SRSEL_AMP_INHIBIT);
    // either panel can force manual
    assign manual     = ~auto_in | rem_manual_in;
    // remote selection overrides the local selector
    assign man_choice = rem_sel_en_in ? rem_sel_in : local_sel_in;
    // swap only toward a strictly healthier stream
    assign want_swap  = (rank[sel] > rank[~sel]);

    always_comb begin
        if (manual) begin
            target = man_choice;
        end else if (want_swap) begin
            target = ~sel;
        end else begin
            target = sel;
        end
    end

    // tell-back agrees with selection on both switches
    assign tell_ok = (tx_tell_in == (sel ? 2'h2 : 2'h1)) && (rx_tell_in == (sel ? 2'h2 : 2'h1));

    ////////////////////////////////////////////////////////////////////////////
    // changeover sequencer, next values
    always_comb begin
        next_state    = state;
        next_sel      = sel;
        next_cnt      = cnt;
        next_coil     = 2'h0;
        next_sw_fault = sw_fault;
        next_nv_wr    = 1'h0;
        // dark timer runs down to zero
        next_blank    = (blank != 32'h0) ? blank - 32'h1 : 32'h0;
        case (state)
            SRSEL_BOOT: begin
                // restore the stored stream, no coil pulse: the switches held it
                next_sel   = nv_stream_in;
                next_cnt   = 32'h0;
                next_state = SRSEL_SETTLE;
            end
            SRSEL_IDLE: begin
                if (target != sel) begin
                    // one changeover drives all three paths
                    next_sel   = target;
                    next_coil  = target ? 2'h2 : 2'h1;
                    next_cnt   = 32'h0;
                    next_blank = BLANK;
                    next_nv_wr = 1'h1;
                    next_state = SRSEL_PULSE;
                end else if (!tell_ok) begin
                    next_sw_fault = 1'h1;
                end
            end
            SRSEL_PULSE: begin
                // coil held only for the pulse time
                next_cnt  = cnt + 32'h1;
                next_coil = coil;
                if (cnt >= COIL - 1) begin
                    next_coil  = 2'h0;
                    next_state = SRSEL_SETTLE;
                end
            end
            SRSEL_SETTLE: begin
                // sequence ends at tell-back match or the maximum time
                next_cnt = cnt + 32'h1;
                if (tell_ok) begin
                    next_sw_fault = 1'h0;
                    next_state    = SRSEL_IDLE;
                end else if (cnt >= SW_MAX - 1) begin
                    next_sw_fault = 1'h1;
                    next_state    = SRSEL_IDLE;
                end
            end
            default: begin
                next_state = SRSEL_IDLE;
            end
        endcase
    end

    // changeover sequencer, registers
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state    <= SRSEL_BOOT;
            sel      <= RST_STREAM;
            cnt      <= 32'h0;
            blank    <= BLANK;            // dark after power-up
            coil     <= 2'h0;
            sw_fault <= 1'h0;
            nv_wr    <= 1'h0;
        end else begin
            state    <= next_state;
            sel      <= next_sel;
            cnt      <= next_cnt;
            blank    <= next_blank;
            coil     <= next_coil;
            sw_fault <= next_sw_fault;
            nv_wr    <= next_nv_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // indicators and amplifier control, next values
    always_comb begin
        // one-hot selection indicators
        next_stat.sel1     = (sel == STREAM_1);
        next_stat.sel2     = (sel == STREAM_2);
        // fault masked while dark
        next_stat.sw_fault = sw_fault & (blank == 32'h0);
        next_stat.fault1   = (rank[0] != RANK_OK);
        next_stat.fault2   = (rank[1] != RANK_OK);
        // only the on-line amplifier may run
        case (amp_ctl_in)
            SRSEL_AMP_INHIBIT:  next_amp_en = 2'h0;
            SRSEL_AMP_ACTIVATE: next_amp_en = sel ? 2'h2 : 2'h1;
            SRSEL_AMP_REMOTE:   next_amp_en = rem_amp_act_in ? (sel ? 2'h2 : 2'h1) : 2'h0;
            default:            next_amp_en = 2'h0;
        endcase
    end

    // indicators and amplifier control, registers
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            stat   <= '0;
            amp_en <= 2'h0;
        end else begin
            stat   <= next_stat;
            amp_en <= next_amp_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    // every path gets the same coil in the same cycle
    assign coil_out.tx_rf  = coil;
    assign coil_out.rx_rf  = coil;
    assign coil_out.if_rly = coil;
    assign nv_write_out    = nv_wr;
    assign nv_stream_out   = sel;
    assign status_out      = stat;
    assign rem_status_out  = stat;
    assign amp_en_out      = amp_en;

endmodule : srsel_top

// ### design/srsel_pkg.sv
/*
 * srsel_pkg: constants, state and carrier types of the stream redundancy selector.
 * Assumes a single 100 MHz clock; long counts are overridden as top parameters in simulation.
 */
// How it works
// - restore last on-line stream after power-up
// - manual mode follows local stream selector
// - auto mode swaps on fault if off-line serviceable
// - changeover completes within one second maximum
// - tx RF, rx RF, IF commands pulse together
// - latching coils pulsed only on a change
// - decode each stream into warm-up and hardware
// - warm-up alarm from reference oscillator not stable
// - config input ignores warm-up alarms on both
// - monitor RF switch tell-back, flag switch fault
// - manual choice local or remote selection input
// - separate selected and fault status outputs
// - remote reports faults, takes mode, selection, amplifier
// - amplifier inhibit disables both, overrides all
// - switch fault indicator blanked five seconds
// - warm-up swap only to fully healthy stream
// - hardware fault ranks above warm-up alarm
package srsel_pkg;

    // clock and times
    localparam int unsigned CLK_HZ      = 100_000_000;  // system clock rate
    localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000; // cycles in one millisecond
    localparam int unsigned SW_MAX_MS   = 1000;          // longest switching sequence
    localparam int unsigned SW_TYP_MS   = 200;           // typical switching sequence, used as coil pulse
    localparam int unsigned BLANK_MS    = 5000;          // switch fault indicator dark time
    localparam int unsigned SW_MAX_CYC  = SW_MAX_MS * CYC_PER_MS; // longest time rounds down, exact here
    localparam int unsigned SW_TYP_CYC  = SW_TYP_MS * CYC_PER_MS;
    localparam int unsigned BLANK_CYC   = BLANK_MS * CYC_PER_MS;

    // stream encoding
    localparam logic        STREAM_1    = 1'h0;          // stream 1 on line
    localparam logic        STREAM_2    = 1'h1;          // stream 2 on line
    localparam logic        RST_STREAM  = STREAM_1;      // held only until the stored choice loads

    // health rank, worse is larger
    localparam logic [1:0]  RANK_OK     = 2'h0;
    localparam logic [1:0]  RANK_WARM   = 2'h1;
    localparam logic [1:0]  RANK_HW     = 2'h2;

    // alarm lines of one transceiver
    typedef struct packed {
        logic ref_warm;   // reference oscillator not yet stable
        logic conv;       // converter module fault
        logic lna;        // lna fault
        logic amp;        // amplifier module fault, latched
        logic temp;       // amplifier temperature alarm
        logic fan;        // amplifier fan fault, latched
        logic out;        // amplifier output alarm
    } srsel_alarm_t;

    // status outputs
    typedef struct packed {
        logic sel1;       // stream 1 selected
        logic sel2;       // stream 2 selected
        logic sw_fault;   // switch fault
        logic fault1;     // stream 1 fault
        logic fault2;     // stream 2 fault
    } srsel_status_t;

    // one coil command set, one bit per stream
    typedef struct packed {
        logic [1:0] tx_rf;  // transmit RF switch coils
        logic [1:0] rx_rf;  // receive RF switch coils
        logic [1:0] if_rly; // IF latching relay coils
    } srsel_coil_t;

    // amplifier control selector
    typedef enum logic [1:0] {
        SRSEL_AMP_INHIBIT,
        SRSEL_AMP_REMOTE,
        SRSEL_AMP_ACTIVATE
    } srsel_amp_t;

    // changeover sequencer
    typedef enum logic [1:0] {
        SRSEL_BOOT,
        SRSEL_IDLE,
        SRSEL_PULSE,
        SRSEL_SETTLE
    } srsel_state_t;

endpackage : srsel_pkg

// ### design/srsel_health.sv
/*
 * srsel_health: per-stream alarm decoding into a health rank.
 * Assumes alarm lines are synchronous and already debounced.
 */
`timescale 1ns/1ps
module srsel_health
    import srsel_pkg::*;
(
    input  wire logic         mclk_in,      // system clock
    input  wire logic         sys_rst_in,   // synchronous reset
    input  srsel_alarm_t      alarm_in [2], // alarm lines per stream
    input  wire logic         ign_warm_in,  // ignore warm-up alarms
    input  wire logic         fan_en_in,    // recognise fan faults
    input  wire logic         amp_inh_in,   // inhibit clears latched faults
    output logic [1:0]        rank_out [2]  // health rank per stream
);

    ////////////////////////////////////////////////////////////////////////////
    // one decoder per stream
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_strm
            logic latch;       // held amplifier or fan fault
            logic next_latch;  // next value of latch
            logic hw;          // any hardware fault
            logic warm;        // warm-up alarm seen

            // latched faults stay until the amplifier is inhibited;
            // a fault still present during inhibit sets again, so set wins over clear
            always_comb begin
                next_latch = alarm_in[g].amp | (alarm_in[g].fan & fan_en_in) | (latch & ~amp_inh_in);
            end

            always_ff @(posedge mclk_in) begin
                if (sys_rst_in) begin
                    latch <= 1'h0;
                end else begin
                    latch <= next_latch;
                end
            end

            // two conditions per stream
            assign hw   = latch | alarm_in[g].conv | alarm_in[g].lna | alarm_in[g].temp
                        | alarm_in[g].out;
            assign warm = alarm_in[g].ref_warm & ~ign_warm_in;

            // hardware outranks warm-up
            assign rank_out[g] = hw ? RANK_HW : (warm ? RANK_WARM : RANK_OK);
        end
    endgenerate

endmodule : srsel_health

// ### sim/srsel_switch_model.sv
/* srsel_switch_model: one latching RF transfer switch with tell-back contacts.
 * Assumes the coil pair of one path from srsel_top; stuck_in stops it moving. */
`timescale 1ns/1ps
module srsel_switch_model #(
    parameter int unsigned DELAY = 4,    // cycles of coil drive before it moves
    parameter logic        INIT  = 1'h1  // position left from before power-up
) (
    input  wire logic       mclk_in,  // system clock
    input  wire logic [1:0] coil_in,  // bit0 stream 1 coil, bit1 stream 2 coil
    input  wire logic       stuck_in, // jammed mechanics
    output logic      [1:0] tell_out  // tell-back, one bit per stream
);
    logic        pos = INIT; // latched position, 1 = stream 2
    int unsigned cnt = 0;    // coil drive so far

    // position moves only under coil drive, else holds
    always_ff @(posedge mclk_in) begin
        if (coil_in != 2'h0 && !stuck_in) begin
            cnt <= cnt + 1;
            if (cnt + 1 == DELAY) pos <= coil_in[1];
        end else begin
            cnt <= 0;
        end
    end

    assign tell_out = {pos, !pos};
endmodule : srsel_switch_model

// ### sim/srsel_top_checker.sv
/* srsel_top_checker: port assertions on srsel_top.
 * Assumes it is bound into srsel_top and given the same timing parameters. */
`timescale 1ns/1ps
module srsel_top_checker
    import srsel_pkg::*;
#(
    parameter int unsigned SW_MAX = 40,
    parameter int unsigned COIL   = 8,
    parameter int unsigned BLANK  = 60
) (
    input wire logic    mclk_in,
    input wire logic    sys_rst_in,
    input srsel_alarm_t alarm_in [2],
    input srsel_amp_t   amp_ctl_in,
    input srsel_coil_t  coil_out,
    input wire logic    nv_write_out,
    input wire logic    nv_stream_out,
    input srsel_status_t status_out,
    input srsel_status_t rem_status_out,
    input wire logic [1:0] amp_en_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    int unsigned coil_cnt;  // consecutive coil-high cycles
    int unsigned blank_cnt; // cycles since reset or changeover, saturating

    // helper counters; blank lags the design by a cycle, hence slack below
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            coil_cnt  <= 0;
            blank_cnt <= 0;
        end else begin
            coil_cnt  <= (coil_out.tx_rf != 2'h0) ? coil_cnt + 1 : 0;
            blank_cnt <= nv_write_out ? 0 : ((blank_cnt < BLANK) ? blank_cnt + 1 : blank_cnt);
        end
    end
    ////////////////////////////////////////
    property p_paths; coil_out.tx_rf == coil_out.rx_rf && coil_out.rx_rf == coil_out.if_rly; endproperty
    a_paths: assert property (p_paths) else $error("coil paths differ");
    property p_excl; coil_out.if_rly != 2'h3; endproperty
    a_excl: assert property (p_excl) else $error("both coils driven");
    property p_len; $fell(coil_out.if_rly != 2'h0) |-> coil_cnt == COIL; endproperty
    a_len: assert property (p_len) else $error("coil pulse length wrong");
    property p_cause; $rose(coil_out.if_rly != 2'h0) |-> nv_write_out && coil_out.if_rly == {nv_stream_out, !nv_stream_out}; endproperty
    a_cause: assert property (p_cause) else $error("coil pulse without stored change");
    property p_store; nv_write_out |=> !nv_write_out && status_out.sel2 == $past(nv_stream_out); endproperty
    a_store: assert property (p_store) else $error("store pulse or indicator wrong");
    property p_blank; status_out.sw_fault |-> blank_cnt + 2 >= BLANK; endproperty
    a_blank: assert property (p_blank) else $error("switch fault shown while dark");
    property p_remote; rem_status_out == status_out; endproperty
    a_remote: assert property (p_remote) else $error("remote status differs");
    property p_inhibit; amp_ctl_in == SRSEL_AMP_INHIBIT |=> amp_en_out == 2'h0; endproperty
    a_inhibit: assert property (p_inhibit) else $error("amplifier on while inhibited");
    property p_hw; $past(alarm_in[1].conv) && !$past(sys_rst_in) |-> status_out.fault2; endproperty
    a_hw: assert property (p_hw) else $error("hardware fault not flagged");
    property p_onehot; status_out.sel1 |-> !status_out.sel2; endproperty
    a_onehot: assert property (p_onehot) else $error("both streams shown selected");
    c_swap: cover property (nv_write_out);
    c_swf: cover property (status_out.sw_fault);
    c_amp: cover property (amp_en_out != 2'h0);
endmodule : srsel_top_checker

bind srsel_top srsel_top_checker #(.SW_MAX(SW_MAX), .COIL(COIL), .BLANK(BLANK)) srsel_top_checker_inst (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .alarm_in(alarm_in), .amp_ctl_in(amp_ctl_in),
    .coil_out(coil_out), .nv_write_out(nv_write_out), .nv_stream_out(nv_stream_out),
    .status_out(status_out), .rem_status_out(rem_status_out), .amp_en_out(amp_en_out));

// ### sim/srsel_top_tb.sv
/* srsel_top_tb: directed tests of srsel_top with two switch models.
 * Assumes short sim counts; inputs change at the falling edge. */
`timescale 1ns/1ps
module srsel_top_tb
    import srsel_pkg::*;
;
    localparam int unsigned COIL = 8; // shortened coil pulse
    logic          mclk = 0, rst = 1, ign_warm = 0, auto_m = 0, rem_man = 0, lsel = 1;
    logic          rsel_en = 0, rsel = 0, amp_act = 0, stuck = 0, nv_wr, nv_out;
    logic    [1:0] tx_tell, rx_tell, amp_en;
    srsel_alarm_t  alarm [2];
    srsel_amp_t    amp_ctl = SRSEL_AMP_INHIBIT;
    srsel_coil_t   coil;
    srsel_status_t st, rem_st;
    int            mismatches = 0, checked = 0, pulses = 0;

    always #5 mclk = ~mclk;
    always @(posedge mclk) if (nv_wr) pulses++; // changeovers seen

    srsel_top #(.SW_MAX(40), .COIL(COIL), .BLANK(60)) srsel_top_inst (
        .mclk_in(mclk), .sys_rst_in(rst), .alarm_in(alarm), .ign_warm_in(ign_warm), .fan_en_in(1'b0),
        .auto_in(auto_m), .rem_manual_in(rem_man), .local_sel_in(lsel), .rem_sel_en_in(rsel_en),
        .rem_sel_in(rsel), .amp_ctl_in(amp_ctl), .rem_amp_act_in(amp_act), .tx_tell_in(tx_tell),
        .rx_tell_in(rx_tell), .nv_stream_in(1'b1), .coil_out(coil), .nv_write_out(nv_wr),
        .nv_stream_out(nv_out), .status_out(st), .rem_status_out(rem_st), .amp_en_out(amp_en));
    srsel_switch_model srsel_switch_model_inst (.mclk_in(mclk), .coil_in(coil.tx_rf), .stuck_in(stuck),
        .tell_out(tx_tell));
    srsel_switch_model srsel_switch_model_rx_inst (.mclk_in(mclk), .coil_in(coil.rx_rf), .stuck_in(1'b0),
        .tell_out(rx_tell));
    ////////////////////////////////////////
    task automatic cmp(input string name, input logic [1:0] exp, input logic [1:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    // changeover to stream s must start within 20 cycles, well under 1 s
    task automatic swap(input logic s);
        int i;
        i = 0;
        while (nv_wr !== 1'b1 && i < 20) begin
            tick(1);
            i++;
        end
        cmp("changeover", 2'h1, {1'b0, nv_wr});
        cmp("coil", {s, !s}, coil.if_rly);
        tick(COIL + 6);
        cmp("coil off", 2'h0, coil.if_rly);
        cmp("selected", {s, !s}, {st.sel2, st.sel1});
    endtask : swap

    // nothing may switch for n cycles
    task automatic hold(input int n);
        int p;
        p = pulses;
        tick(n);
        cmp("no changeover", 2'h0, {1'b0, pulses != p});
    endtask : hold

    task automatic close_out;
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    ////////////////////////////////////////
    // watchdog: the tests take about 300 cycles
    initial begin
        #(20000 * 10);
        mismatches++;
        close_out();
    end

    initial begin
        alarm[0] = '0;
        alarm[1] = '0;
        tick(6);
        rst = 0;
        tick(10);
        cmp("boot stream", 2'h2, {st.sel2, st.sel1});
        cmp("boot pulses", 2'h0, {1'b0, pulses != 0});
        lsel = 0;
        swap(0);
        rsel_en = 1;
        rsel = 1;
        swap(1);
        lsel = 1;
        rsel_en = 0;
        hold(20);
        auto_m = 1;
        alarm[1].conv = 1;
        swap(0);
        cmp("fault flags", 2'h2, {st.fault2, st.fault1});
        alarm[0].ref_warm = 1;
        hold(30);
        cmp("fault flags", 2'h3, {st.fault2, st.fault1});
        alarm[1].conv = 0;
        alarm[1].ref_warm = 1;
        hold(30);
        ign_warm = 1;
        tick(3);
        cmp("fault flags", 2'h0, {st.fault2, st.fault1});
        ign_warm = 0;
        alarm[1].ref_warm = 0;
        swap(1);
        rem_man = 1;
        lsel = 0;
        swap(0);
        rem_man = 0;
        swap(1);
        alarm[0].ref_warm = 0;
        amp_ctl = SRSEL_AMP_ACTIVATE;
        tick(3);
        cmp("amp", 2'h2, amp_en);
        amp_ctl = SRSEL_AMP_REMOTE;
        tick(3);
        cmp("amp", 2'h0, amp_en);
        amp_act = 1;
        tick(3);
        cmp("amp", 2'h2, amp_en);
        amp_ctl = SRSEL_AMP_INHIBIT;
        tick(3);
        cmp("amp", 2'h0, amp_en);
        stuck = 1;
        auto_m = 0;
        swap(0);
        tick(30);
        cmp("switch fault", 2'h0, {1'b0, st.sw_fault});
        tick(25);
        cmp("switch fault", 2'h1, {1'b0, st.sw_fault});
        stuck = 0;
        lsel = 1;
        swap(1);
        cmp("switch fault", 2'h0, {1'b0, st.sw_fault});
        amp_ctl = SRSEL_AMP_ACTIVATE;
        alarm[0].amp = 1;
        tick(2);
        alarm[0].amp = 0;
        tick(3);
        cmp("latched fault", 2'h1, {st.fault2, st.fault1});
        amp_ctl = SRSEL_AMP_INHIBIT;
        tick(3);
        cmp("latched fault", 2'h0, {st.fault2, st.fault1});
        close_out();
    end
endmodule : srsel_top_tb
